// ===== logic/bus_controller.sv
// Clock source end: frames, output check bytes, input checking
//
// The implementer's own choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "check_codec_defines.svh"
module bus_controller #(
  parameter logic [7:0] OUT_BASE = `OUT_BASE_DEF,
  parameter logic [7:0] IN_BASE  = `IN_BASE_DEF
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  check_link_if.ctl        link,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest
);
  check_codec_pkg::link_state_e state_q;
  logic [5:0]       div_q;
  logic [7:0]       addr_q;
  logic [3:0]       chan_q;
  logic             clk_q, sync_q, dout_q, din_s1_q, din_s2_q;
  logic [4:0]       ctrl_q;
  logic [31:0]      out_q, frame_q, rdata_q;
  logic             wait_q, fault9_q, in_err_q, f9_rx_q;
  logic [1:0][7:0]  rdat_q, rchk_q, enc_out, enc_in;
  logic [1:0]       elig_out, elig_in, in_bad;
  logic [15:0]      in_word_q;
  logic [5:0]       slot_o, slot_i;
  logic [7:0]       nxt_addr;
  logic             half_done, in_on, next_bit, acc;

  assign link.bus_clk   = clk_q;
  assign link.bus_sync  = sync_q;
  assign link.bus_dout  = dout_q;
  assign avs_readdata   = rdata_q;
  assign avs_waitrequest = wait_q;

  genvar k;
  generate
    for (k = 0; k < 2; k++) begin : g_enc
      check_byte_encoder u_out (
        .start_addr (OUT_BASE + 8'(8 * k)), .slot_chan (chan_q),
        .ms_output  (ctrl_q[`CTRL_MS]), .enc (enc_out[k]),
        .eligible   (elig_out[k]));
      check_byte_encoder u_in (
        .start_addr (IN_BASE + 8'(8 * k)), .slot_chan (chan_q),
        .ms_output  (1'b0), .enc (enc_in[k]), .eligible (elig_in[k]));
      assign in_bad[k] = in_on && ((rchk_q[k] ^ enc_in[k]) != rdat_q[k]);
    end
  endgenerate

  assign in_on     = ctrl_q[`CTRL_IN_EN] && (&elig_in);
  assign half_done = div_q == 6'(`LINK_HALF_CYC - 1);
  assign nxt_addr  = (state_q == check_codec_pkg::LINK_SYNC) ? 8'h00 :
                     addr_q + 8'h01;
  assign acc       = avs_read || avs_write;
  assign slot_i    = check_codec_pkg::slot_of(addr_q, IN_BASE);

  // Bit driven at the next address
  always_comb begin
    slot_o   = check_codec_pkg::slot_of(nxt_addr, OUT_BASE);
    next_bit = 1'b0;
    if (nxt_addr >= `CHAN_BIT_LO && nxt_addr <= `CHAN_BIT_HI) begin
      next_bit = chan_q[2'(nxt_addr - `CHAN_BIT_LO)];
    end else if (nxt_addr >= `CHAN_INV_LO && nxt_addr <= `CHAN_INV_HI) begin
      next_bit = (ctrl_q[`CTRL_OUT_EN] || ctrl_q[`CTRL_IN_EN]) &&
                 !chan_q[2'(nxt_addr - `CHAN_INV_LO)];
    end else if (slot_o[5] && !slot_o[4]) begin
      next_bit = frame_q[{slot_o[3], slot_o[2:0]}];
    end else if (slot_o[5]) begin
      next_bit = (ctrl_q[`CTRL_OUT_EN] && (&elig_out)) ?
                 frame_q[{slot_o[3], slot_o[2:0]}] ^
                 enc_out[slot_o[3]][slot_o[2:0]] :
                 frame_q[{1'b1, slot_o[3], slot_o[2:0]}];
    end
  end

  always_ff @(posedge core_clk) begin
    din_s2_q <= din_s1_q;
    din_s1_q <= link.bus_din;
  end

  // Frame sequencer and link clock divider
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= check_codec_pkg::LINK_IDLE;
      div_q   <= 6'h00;
      addr_q  <= 8'h00;
      chan_q  <= 4'h0;
      clk_q   <= 1'b0;
      sync_q  <= 1'b0;
      dout_q  <= 1'b0;
      frame_q <= `OUT_RESET;
    end else begin
      div_q <= div_q + 6'h01;
      unique case (state_q)
        check_codec_pkg::LINK_IDLE: begin
          div_q <= 6'h00;
          if (ctrl_q[`CTRL_RUN]) begin
            state_q <= check_codec_pkg::LINK_SYNC;
            sync_q  <= 1'b1;
          end
        end
        check_codec_pkg::LINK_SYNC: begin
          if (div_q == 6'(`SYNC_CYC - 1)) begin
            state_q <= check_codec_pkg::LINK_LOW;
            div_q   <= 6'h00;
            sync_q  <= 1'b0;
            addr_q  <= 8'h00;
            frame_q <= out_q;
          end
        end
        check_codec_pkg::LINK_LOW: begin
          if (half_done) begin
            state_q <= check_codec_pkg::LINK_HIGH;
            div_q   <= 6'h00;
            clk_q   <= 1'b1;
          end
        end
        check_codec_pkg::LINK_HIGH: begin
          if (half_done) begin
            div_q <= 6'h00;
            clk_q <= 1'b0;
            if (addr_q == `FRAME_LAST) begin
              chan_q  <= chan_q + 4'h1;
              sync_q  <= ctrl_q[`CTRL_RUN];
              state_q <= ctrl_q[`CTRL_RUN] ? check_codec_pkg::LINK_SYNC :
                         check_codec_pkg::LINK_IDLE;
            end else begin
              addr_q  <= nxt_addr;
              state_q <= check_codec_pkg::LINK_LOW;
            end
          end
        end
      endcase
      if (state_q == check_codec_pkg::LINK_SYNC && div_q ==
          6'(`SYNC_CYC - 1)) begin
        dout_q <= next_bit;
      end else if (state_q == check_codec_pkg::LINK_HIGH && half_done &&
                   addr_q != `FRAME_LAST) begin
        dout_q <= next_bit;
      end else if (state_q == check_codec_pkg::LINK_HIGH && half_done) begin
        dout_q <= 1'b0;
      end
    end
  end

  // Input capture at the end of each high half
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdat_q  <= '0;
      rchk_q  <= '0;
      f9_rx_q <= 1'b0;
    end else if (state_q == check_codec_pkg::LINK_HIGH && half_done) begin
      if (addr_q == `FAULT_ADDR) begin
        f9_rx_q <= din_s2_q;
      end
      if (slot_i[5] && slot_i[4]) begin
        rchk_q[slot_i[3]][slot_i[2:0]] <= din_s2_q;
      end else if (slot_i[5]) begin
        rdat_q[slot_i[3]][slot_i[2:0]] <= din_s2_q;
      end
    end
  end

  // Input acceptance at frame end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      in_word_q <= 16'h0000;
      fault9_q  <= 1'b0;
      in_err_q  <= 1'b0;
    end else begin
      if (state_q == check_codec_pkg::LINK_HIGH && half_done &&
          addr_q == `FRAME_LAST) begin
        fault9_q <= f9_rx_q;
        for (int b = 0; b < 2; b++) begin
          if (!(ctrl_q[`CTRL_PAIR_IN] ? |in_bad : in_bad[b])) begin
            in_word_q[8 * b +: 8] <= rdat_q[b];
          end
        end
      end
      if (state_q == check_codec_pkg::LINK_HIGH && half_done &&
          addr_q == `FRAME_LAST && |in_bad) begin
        in_err_q <= 1'b1;
      end else if (avs_write && !wait_q && avs_address == `REG_STAT &&
                   avs_writedata[`STAT_IN_ERR]) begin
        in_err_q <= 1'b0;
      end
    end
  end

  // Register slave, one wait cycle per access
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
      ctrl_q  <= `CTRL_RESET;
      out_q   <= `OUT_RESET;
    end else begin
      wait_q <= !(acc && wait_q);
      if (avs_read && wait_q) begin
        unique case (avs_address)
          `REG_CTRL: rdata_q <= {27'h0000000, ctrl_q};
          `REG_OUT:  rdata_q <= out_q;
          `REG_STAT: rdata_q <= {8'h00, chan_q, 2'h0, in_err_q,
                                 fault9_q, in_word_q};
          default:   rdata_q <= 32'h00000000;
        endcase
      end
      if (avs_write && !wait_q) begin
        if (avs_address == `REG_CTRL) begin
          ctrl_q <= avs_writedata[4:0];
        end
        if (avs_address == `REG_OUT) begin
          out_q <= avs_writedata;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== logic/check_byte_encoder.sv
// Encoding byte for one protected data byte
`timescale 1ns/1ps
`default_nettype none
`include "check_codec_defines.svh"
module check_byte_encoder (
  input  wire logic [7:0] start_addr,
  input  wire logic [3:0] slot_chan,
  input  wire logic       ms_output,
  output logic      [7:0] enc,
  output logic            eligible
);
  logic [3:0] addr_code;
  logic [3:0] dir_code;

  always_comb begin
    eligible  = (start_addr[7:5] != 3'h0) && !start_addr[4] &&
                (start_addr[2:0] == 3'h0);
    addr_code = {start_addr[7:5], start_addr[3]} - 4'h1;
    dir_code  = ms_output ? `DIR_MS_OUT : `DIR_OTHER;
    enc       = {addr_code, ~slot_chan ^ dir_code};
  end
endmodule
`default_nettype wire

// ===== logic/check_codec_defines.svh
// Constants shared by both ends of the check byte link
`ifndef CHECK_CODEC_DEFINES_SVH
`define CHECK_CODEC_DEFINES_SVH

// Frame layout
`define FRAME_LAST     8'hFF
`define CHAN_BIT_LO    8'h01
`define CHAN_BIT_HI    8'h04
`define CHAN_INV_LO    8'h05
`define CHAN_INV_HI    8'h08
`define FAULT_ADDR     8'h09
`define WORD_SPAN      8'h20
`define OUT_BASE_DEF   8'h20
`define IN_BASE_DEF    8'h40

// Direction codes
`define DIR_MS_OUT     4'h8
`define DIR_OTHER      4'h0

// Ride-through
`define RIDE_LIMIT     2'h3
`define RIDE_LAST      2'h2

// Link timing
`define CORE_MHZ       40
`define LINK_HALF_NS   100
`define LINK_HALF_CYC  ((`LINK_HALF_NS * `CORE_MHZ + 999) / 1000)
`define SYNC_NS        800
`define SYNC_CYC       ((`SYNC_NS * `CORE_MHZ + 999) / 1000)

// Controller registers
`define REG_CTRL       4'h0
`define REG_OUT        4'h4
`define REG_STAT       4'h8
`define CTRL_RUN       0
`define CTRL_MS        1
`define CTRL_OUT_EN    2
`define CTRL_IN_EN     3
`define CTRL_PAIR_IN   4
`define STAT_FAULT9    16
`define STAT_IN_ERR    17
`define STAT_CHAN_LO   20
`define CTRL_RESET     5'h00
`define OUT_RESET      32'h00000000

`endif

// ===== logic/check_codec_pkg.sv
// Types and helpers shared by both ends
`default_nettype none
package check_codec_pkg;

  typedef enum logic [3:0] {
    LINK_IDLE = 4'b0001,
    LINK_SYNC = 4'b0010,
    LINK_LOW  = 4'b0100,
    LINK_HIGH = 4'b1000
  } link_state_e;

  // Hit flag, check half, byte index, bit index of a word region
  function automatic logic [5:0] slot_of(input logic [7:0] addr,
                                          input logic [7:0] base);
    logic [7:0] off;
    off = addr - base;
    slot_of = {off < 8'h20, off[4:0]};
  endfunction

endpackage
`default_nettype wire

// ===== logic/check_link_if.sv
// Serial control link between controller and output device
`timescale 1ns/1ps
`default_nettype none
interface check_link_if;
  logic bus_clk;
  logic bus_sync;
  logic bus_dout;
  logic bus_din;
  modport ctl (output bus_clk, output bus_sync, output bus_dout,
               input bus_din);
  modport dev (input bus_clk, input bus_sync, input bus_dout,
               output bus_din);
endinterface
`default_nettype wire

// ===== logic/io_device_codec.sv
// Output device end: verifies output check bytes, sends input check bytes
`timescale 1ns/1ps
`default_nettype none
`include "check_codec_defines.svh"
module io_device_codec #(
  parameter logic [7:0] OUT_BASE = `OUT_BASE_DEF,
  parameter logic [7:0] IN_BASE  = `IN_BASE_DEF
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  check_link_if.dev        link,
  input  wire logic        cdr_out_en,
  input  wire logic        cdr_in_en,
  input  wire logic        pair_out,
  input  wire logic        ride_en,
  input  wire logic        ms_mode,
  input  wire logic [15:0] in_word,
  output logic      [15:0] out_word,
  output logic      [15:0] out_ext,
  output logic             out_fault,
  output logic             frame_done,
  output logic             frame_rej
);
  logic             clk_s1_q, clk_s2_q, clk_s3_q;
  logic             sync_s1_q, sync_s2_q;
  logic             dout_s1_q, dout_s2_q;
  logic             rise, fall, frame_end;
  logic [7:0]       addr_q, nxt_addr;
  logic [3:0]       chan_q, inv_q;
  logic [1:0][7:0]  rdat_q, rchk_q, held_q, held_d, tx_q;
  logic [1:0][7:0]  enc_out, enc_in;
  logic [1:0]       elig_out, elig_in, byte_bad, rej;
  logic             chk_on, in_on, chan_bad, frame_bad, fault_d;
  logic [1:0]       ride_q;
  logic             fault_q, din_q, done_q, rej_q, next_bit;
  logic [15:0]      out_q, ext_q;
  logic [5:0]       slot_r, slot_t;

  assign link.bus_din = din_q;
  assign out_word     = out_q;
  assign out_ext      = ext_q;
  assign out_fault    = fault_q;
  assign frame_done   = done_q;
  assign frame_rej    = rej_q;

  // Link pins pass two flops before use
  always_ff @(posedge core_clk) begin
    clk_s1_q  <= link.bus_clk;
    clk_s2_q  <= clk_s1_q;
    clk_s3_q  <= clk_s2_q;
    sync_s1_q <= link.bus_sync;
    sync_s2_q <= sync_s1_q;
    dout_s1_q <= link.bus_dout;
    dout_s2_q <= dout_s1_q;
  end

  assign rise      = clk_s2_q && !clk_s3_q;
  assign fall      = !clk_s2_q && clk_s3_q;
  assign frame_end = fall && (addr_q == `FRAME_LAST);
  assign nxt_addr  = sync_s2_q ? 8'h00 : addr_q + 8'h01;
  assign slot_r    = check_codec_pkg::slot_of(addr_q, OUT_BASE);

  genvar k;
  generate
    for (k = 0; k < 2; k++) begin : g_enc
      check_byte_encoder u_out (
        .start_addr (OUT_BASE + 8'(8 * k)), .slot_chan (chan_q),
        .ms_output  (ms_mode), .enc (enc_out[k]),
        .eligible   (elig_out[k]));
      check_byte_encoder u_in (
        .start_addr (IN_BASE + 8'(8 * k)), .slot_chan (chan_q),
        .ms_output  (1'b0), .enc (enc_in[k]), .eligible (elig_in[k]));
      assign byte_bad[k] = (rchk_q[k] ^ enc_out[k]) != rdat_q[k];
      assign rej[k] = chk_on && (chan_bad ||
                                 (pair_out ? |byte_bad : byte_bad[k]));
      assign held_d[k] = rej[k] ? held_q[k] : rdat_q[k];
    end
  endgenerate

  assign chk_on    = cdr_out_en && (&elig_out);
  assign in_on     = cdr_in_en && (&elig_in);
  assign chan_bad  = inv_q != ~chan_q;
  assign frame_bad = chk_on && (chan_bad || |byte_bad);
  assign fault_d   = frame_bad &&
                     (fault_q || !ride_en || ride_q == `RIDE_LAST);

  // Frame address follows link clock falls
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      addr_q <= 8'h00;
    end else if (sync_s2_q || fall) begin
      addr_q <= nxt_addr;
    end
  end

  // Output frame capture on rising link clock
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      chan_q <= 4'h0;
      inv_q  <= 4'hF;
      rdat_q <= '0;
      rchk_q <= '0;
    end else if (rise) begin
      if (addr_q >= `CHAN_BIT_LO && addr_q <= `CHAN_BIT_HI) begin
        chan_q[2'(addr_q - `CHAN_BIT_LO)] <= dout_s2_q;
      end
      if (addr_q >= `CHAN_INV_LO && addr_q <= `CHAN_INV_HI) begin
        inv_q[2'(addr_q - `CHAN_INV_LO)] <= dout_s2_q;
      end
      if (slot_r[5] && slot_r[4]) begin
        rchk_q[slot_r[3]][slot_r[2:0]] <= dout_s2_q;
      end else if (slot_r[5]) begin
        rdat_q[slot_r[3]][slot_r[2:0]] <= dout_s2_q;
      end
    end
  end

  // Accept, ride through or declare fault at frame end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      held_q  <= '0;
      ride_q  <= 2'h0;
      fault_q <= 1'b0;
      out_q   <= 16'h0000;
      ext_q   <= 16'h0000;
      done_q  <= 1'b0;
      rej_q   <= 1'b0;
    end else begin
      done_q <= frame_end;
      rej_q  <= frame_end && frame_bad;
      if (frame_end) begin
        held_q  <= held_d;
        fault_q <= fault_d;
        if (!frame_bad) begin
          ride_q <= 2'h0;
        end else if (ride_en && ride_q != `RIDE_LIMIT) begin
          ride_q <= ride_q + 2'h1;
        end
        out_q <= fault_d ? 16'h0000 : {held_d[1], held_d[0]};
        if (!chk_on) begin
          ext_q <= {rchk_q[1], rchk_q[0]};
        end
      end
    end
  end

  // Bit this device drives at the next address
  always_comb begin
    slot_t   = check_codec_pkg::slot_of(nxt_addr, IN_BASE);
    next_bit = 1'b0;
    if (nxt_addr == `FAULT_ADDR) begin
      next_bit = fault_d && frame_end || fault_q && !frame_end;
    end else if (slot_t[5] && !slot_t[4]) begin
      next_bit = tx_q[slot_t[3]][slot_t[2:0]];
    end else if (slot_t[5] && in_on) begin
      next_bit = tx_q[slot_t[3]][slot_t[2:0]] ^
                 enc_in[slot_t[3]][slot_t[2:0]];
    end
  end

  // Input word snapshot and link data drive
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_q  <= '0;
      din_q <= 1'b0;
    end else begin
      if (sync_s2_q) begin
        tx_q <= {in_word[15:8], in_word[7:0]};
      end
      if (sync_s2_q || fall) begin
        din_q <= next_bit;
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/link_monitor.sv
// Timing checks on the serial check byte link
`timescale 1ns/1ps
`default_nettype none
module link_monitor (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic bus_clk,
  input wire logic bus_sync,
  input wire logic bus_dout,
  input wire logic bus_din
);
  logic [5:0] gap_q;
  logic [8:0] rise_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // Length of the current gap
  always_ff @(posedge core_clk) begin
    gap_q <= (sys_rst || !bus_sync) ? 6'h00 : gap_q + 6'h01;
  end

  // Addresses clocked in the current frame
  always_ff @(posedge core_clk) begin
    if (sys_rst || bus_sync) begin
      rise_q <= 9'h000;
    end else begin
      rise_q <= rise_q + {8'h00, $rose(bus_clk)};
    end
  end

  a_sync_len: assert property ($fell(bus_sync) |-> gap_q == 6'h20)
    else $error("gap not 32 cycles");
  a_sync_cap: assert property (bus_sync |-> gap_q < 6'h20)
    else $error("gap too long");
  a_idle_clk: assert property (bus_sync |-> !bus_clk)
    else $error("link clock runs in gap");
  a_first_addr: assert property (
    $fell(bus_sync) |-> !bus_clk [*4] ##1 bus_clk)
    else $error("first address timing");
  a_clk_high: assert property (
    $rose(bus_clk) |-> bus_clk [*4] ##1 !bus_clk)
    else $error("high half not 4 cycles");
  a_clk_low: assert property (
    $fell(bus_clk) |-> !bus_clk [*4] ##[1:8] (bus_clk || bus_sync))
    else $error("low half timing");
  a_dout_edge: assert property (
    $changed(bus_dout) |-> $fell(bus_clk) || $fell(bus_sync) || bus_sync)
    else $error("data out moved off clock fall");
  a_din_edge: assert property ($changed(bus_din) |-> !bus_clk)
    else $error("data in moved while clock high");
  a_frame_len: assert property (
    $rose(bus_sync) && rise_q != 9'h000 |-> rise_q == 9'h100)
    else $error("frame not 256 addresses");

  c_frame: cover property ($rose(bus_sync) && rise_q == 9'h100);
  c_start: cover property ($fell(bus_sync));
  c_din_one: cover property (bus_din && $rose(bus_clk));
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// Bench joining controller and device over the link
`timescale 1ns/1ps
`default_nettype none
`include "check_codec_defines.svh"
module testbench;
  localparam logic [7:0] OB = 8'h20;
  localparam logic [7:0] IB = 8'h40;
  logic         core_clk      = 1'b0;
  logic         sys_rst       = 1'b1;
  logic [3:0]   avs_address   = 4'h0;
  logic         avs_read      = 1'b0;
  logic         avs_write     = 1'b0;
  logic [31:0]  avs_writedata = 32'h00000000;
  logic [31:0]  avs_readdata;
  logic         avs_waitrequest;
  logic         out_chk_en    = 1'b0;
  logic         in_chk_en     = 1'b0;
  logic         pair_out      = 1'b0;
  logic         ride_en       = 1'b0;
  logic         ms_mode       = 1'b0;
  logic [15:0]  in_word       = 16'h5A3C;
  logic [15:0]  out_word;
  logic [15:0]  out_ext;
  logic         out_fault;
  logic         frame_done;
  logic         frame_rej;
  logic [255:0] dout_q;
  logic [255:0] din_q;
  logic [8:0]   idx_q         = 9'h000;
  logic         clk_seen_q    = 1'b0;
  logic         rej;
  int           failures      = 0;
  int           check_count   = 0;
  int           cycles        = 0;

  check_link_if link ();
  bus_controller #(.OUT_BASE(OB), .IN_BASE(IB)) u_bus_controller (
    .core_clk(core_clk), .sys_rst(sys_rst), .link(link.ctl),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  io_device_codec #(.OUT_BASE(OB), .IN_BASE(IB)) u_io_device_codec (
    .core_clk(core_clk), .sys_rst(sys_rst), .link(link.dev),
    .cdr_out_en(out_chk_en), .cdr_in_en(in_chk_en), .pair_out(pair_out),
    .ride_en(ride_en), .ms_mode(ms_mode), .in_word(in_word),
    .out_word(out_word), .out_ext(out_ext), .out_fault(out_fault),
    .frame_done(frame_done), .frame_rej(frame_rej));
  link_monitor u_link_monitor (.core_clk(core_clk), .sys_rst(sys_rst),
    .bus_clk(link.bus_clk), .bus_sync(link.bus_sync),
    .bus_dout(link.bus_dout), .bus_din(link.bus_din));

  always #12.5 core_clk = ~core_clk;

  // Capture one frame of wire bits by address
  always @(posedge core_clk) begin
    clk_seen_q <= link.bus_clk;
    if (link.bus_sync) begin
      idx_q <= 9'h000;
    end else if (link.bus_clk && !clk_seen_q) begin
      dout_q[idx_q[7:0]] <= link.bus_dout;
    end else if (!link.bus_clk && clk_seen_q) begin
      din_q[idx_q[7:0]] <= link.bus_din;
      idx_q <= idx_q + 9'h001;
    end
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 95000) begin
      failures++;
      close_out();
    end
  end

  function automatic logic [7:0] enc(input logic [7:0] a,
                                     input logic [3:0] ch,
                                     input logic [3:0] dir);
    logic [3:0] code;
    code = {a[7:5], 1'b0} - 4'h1 + {3'h0, a[3]};
    enc = {code, ~ch ^ dir};
  endfunction

  task automatic close_out();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task automatic set_run(input logic [4:0] c, input logic [31:0] o);
    bus_wr(`REG_CTRL, {27'h0, c});
    bus_wr(`REG_OUT, o);
  endtask

  task automatic wait_frame();
    do @(posedge core_clk); while (frame_done !== 1'b1);
    rej = frame_rej;
    @(posedge core_clk);
  endtask

  // Wire contents of the last frame against the encoding
  task automatic check_link(input logic ms, input logic [15:0] ow);
    logic [3:0] ch;
    logic [7:0] a;
    ch = dout_q[4:1];
    chk("chan_inv", {28'h0000000, ~ch}, 32'(dout_q[8:5]));
    for (int b = 0; b < 2; b++) begin
      a = OB + 8'(8 * b);
      chk("out_data", 32'(ow[8*b +: 8]), 32'(dout_q[a +: 8]));
      chk("out_chk", 32'(ow[8*b +: 8] ^ enc(a, ch, ms ? `DIR_MS_OUT
          : `DIR_OTHER)), 32'(dout_q[a + 8'h10 +: 8]));
      a = IB + 8'(8 * b);
      chk("in_data", 32'(in_word[8*b +: 8]), 32'(din_q[a +: 8]));
      chk("in_chk", 32'(in_word[8*b +: 8] ^ enc(a, ch, `DIR_OTHER)),
          32'(din_q[a + 8'h10 +: 8]));
    end
  endtask

  task automatic t_regs();
    logic [31:0] d;
    bus_rd(`REG_CTRL, d);
    chk("ctrl_rst", 32'(`CTRL_RESET), d);
    bus_rd(`REG_OUT, d);
    chk("out_rst", `OUT_RESET, d);
    bus_wr(4'hC, 32'hFFFFFFFF);
    bus_rd(4'hC, d);
    chk("unmapped", 32'h00000000, d);
    chk("fault_rst", 32'h0, 32'({out_fault, out_word}));
    $display("register test done");
  endtask

  task automatic t_clean();
    logic [31:0] d;
    out_chk_en <= 1'b1;
    in_chk_en  <= 1'b1;
    bus_wr(`REG_OUT, 32'h0000A3C5);
    for (int m = 0; m < 2; m++) begin
      ms_mode <= m[0];
      bus_wr(`REG_CTRL, {28'h0, 2'b11, m[0], 1'b1});
      wait_frame();
      for (int f = 0; f < 16 - 15 * m; f++) begin
        wait_frame();
        check_link(m[0], 16'hA3C5);
        chk("clean_rej", 32'h0, 32'(rej));
        chk("clean_word", 32'hA3C5, 32'(out_word));
        bus_rd(`REG_STAT, d);
        chk("stat_in", 32'(in_word), 32'(d[17:0]));
      end
    end
    $display("clean frames test done");
  endtask

  task automatic t_plain();
    logic [31:0] d;
    out_chk_en <= 1'b0;
    in_chk_en  <= 1'b0;
    ms_mode    <= 1'b0;
    set_run(5'h01, 32'h1234ABCD);
    wait_frame();
    wait_frame();
    chk("plain_slot", 32'h1234, 32'({dout_q[OB + 8'h18 +: 8],
        dout_q[OB + 8'h10 +: 8]}));
    chk("plain_out", 32'h1234ABCD, {out_ext, out_word});
    bus_rd(`REG_STAT, d);
    chk("plain_in", 32'(in_word), 32'(d[15:0]));
    $display("plain data test done");
  endtask

  task automatic t_split();
    logic [31:0] d;
    logic [7:0]  c0;
    logic [7:0]  c1;
    out_chk_en <= 1'b1;
    in_chk_en  <= 1'b1;
    ride_en    <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      pair_out <= p[0];
      set_run(5'h0D, 32'h00001111);
      wait_frame();
      wait_frame();
      bus_rd(`REG_STAT, d);
      c0 = 8'h22 ^ enc(OB, d[23:20], `DIR_OTHER);
      c1 = ~(8'h22 ^ enc(OB + 8'h08, d[23:20], `DIR_OTHER));
      set_run(5'h09, {c1, c0, 16'h2222});
      wait_frame();
      chk("split_rej", 32'h1, 32'(rej));
      chk("split_word", p ? 32'h1111 : 32'h1122, 32'(out_word));
    end
    $display("byte pairing test done");
  endtask

  task automatic t_ride();
    logic [31:0] d;
    logic [15:0] hw;
    logic        f_exp;
    pair_out <= 1'b0;
    hw = 16'hBEEF;
    set_run(5'h0D, {16'h0, hw});
    wait_frame();
    wait_frame();
    for (int r = 1; r >= 0; r--) begin
      ride_en <= r[0];
      set_run(5'h09, 32'hFFFF0000);
      for (int f = 1; f <= 3; f++) begin
        wait_frame();
        f_exp = (r == 0) || (f == 3);
        chk("ride_fault", 32'(f_exp), 32'(out_fault));
        chk("ride_word", f_exp ? 32'h0 : 32'(hw), 32'(out_word));
      end
      wait_frame();
      chk("nine_wire", 32'h1, 32'(din_q[9]));
      bus_rd(`REG_STAT, d);
      chk("nine_stat", 32'h1, 32'(d[16]));
      hw = 16'h5A5A;
      set_run(5'h0D, {16'h0, hw});
      wait_frame();
      chk("clear", 32'(hw), 32'({rej, out_fault, out_word}));
    end
    $display("ride through test done");
  endtask

  // Input check errors at the controller, byte and word mode
  task automatic t_in_check();
    logic [31:0] d;
    logic [15:0] old;
    logic [7:0]  e;
    in_chk_en <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      bus_wr(`REG_CTRL, {27'h0000000, p[0], 4'hD});
      wait_frame();
      bus_rd(`REG_STAT, d);
      old = d[15:0];
      e   = enc(IB, d[23:20], `DIR_OTHER);
      in_word <= {8'h77, e};
      wait_frame();
      bus_rd(`REG_STAT, d);
      chk("in_err", 32'h1, 32'(d[17]));
      chk("in_pair", p ? 32'(old) : 32'({old[15:8], e}),
          32'(d[15:0]));
    end
    in_chk_en <= 1'b1;
    wait_frame();
    bus_wr(`REG_STAT, 32'h00020000);
    bus_rd(`REG_STAT, d);
    chk("in_clear", 32'h0, 32'(d[17]));
    $display("input check test done");
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_clean();
    t_plain();
    t_split();
    t_ride();
    t_in_check();
    close_out();
  end
endmodule
`default_nettype wire
